// file: rsf_flags.sv
// Rate sample status flags: per-axis and combined ready and overwrite
`timescale 1ns/1ps
`include "rsf_cfg.svh"
// Functional notes
// - Z overwrite, bit 6, newest sample kept
// - Y overwrite, bit 5, newest sample kept
// - X overwrite, bit 4, newest sample kept
// - Axis overwrite clears on its high-byte read
// - Any-axis ready, bit 3, on any sample
// - Any-axis ready clears after all high reads
// - Z ready bit 2, cleared by Z high read
// - Y ready bit 1, cleared by Y high read
// - X ready bit 0, cleared by X high read
// - All-axes overwrite bit 7, cleared after all reads
// - Entering active mode clears every flag
module rsf_flags (
    input wire logic clk_sys,
    input wire logic rst,
    input wire rsf_pkg::rsf_mode_t mode,
    input wire rsf_pkg::rsf_axes_t sample_done,
    input wire logic [15:0] x_sample,
    input wire logic [15:0] y_sample,
    input wire logic [15:0] z_sample,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rate_sample_flags,
    output logic [47:0] sample_set_r
);
    rsf_pkg::rsf_mode_t mode_prev_r; // Mode one cycle ago
    logic enter_active; // Transition into active mode
    rsf_pkg::rsf_axes_t hi_read; // High-byte read strobes
    // Timing overview
    // Inputs sampled on every rising clock edge
    // Internal flags change at the sampling edge
    // Status byte follows one edge later
    // Sample store follows at the sampling edge itself
    // Host sees each flag two edges after its cause
    // Per-axis behaviour
    // Each axis has one ready and one overwrite flag
    // Ready: set by sample, cleared by high read
    // Overwrite: sample while ready and unread
    // Same-cycle sample and read keeps ready set
    // Same-cycle sample and read leaves overwrite clear
    // Combined behaviour
    // Any-ready rises with any axis sample
    // Any-ready falls once all high bytes read
    // Any new sample restarts the read tracking
    // Complete set collected over one or more cycles
    // All-overwrite: complete set while any-ready set
    // All-overwrite falls once all high bytes read
    // Mode behaviour
    // Entry into active mode clears every flag
    // Entry clear beats any same-cycle sample
    // Low bytes are not decoded here
    // Host must read high byte first per axis
    // Limitations
    // Reads of other addresses are ignored
    // No write path exists in this block
    rsf_pkg::rsf_axes_t ready_w; // Per-axis ready flags
    rsf_pkg::rsf_axes_t over_w; // Per-axis overwrite flags
    rsf_pkg::rsf_axes_t read_seen_r; // High bytes read since last axis sample
    rsf_pkg::rsf_axes_t new_set_r; // Axes sampled in current set
    rsf_pkg::rsf_axes_t read_seen_nxt; // Next read progress
    logic any_ready_r; // Combined ready flag
    logic all_over_r; // Combined overwrite flag
    logic all_read; // Every high byte read
    logic set_done; // Complete new set acquired

    // Address match on a read strobe
    function automatic logic addr_hit(input logic stb, input logic [7:0] a,
                                      input logic [7:0] want);
        addr_hit = stb && (a == want);
    endfunction

    // Decode high-byte reads
    always_comb begin
        hi_read.x = addr_hit(rd_strobe, rd_addr, `RSF_ADDR_OUT_X_HI);
        hi_read.y = addr_hit(rd_strobe, rd_addr, `RSF_ADDR_OUT_Y_HI);
        hi_read.z = addr_hit(rd_strobe, rd_addr, `RSF_ADDR_OUT_Z_HI);
    end

    // Track previous mode
    // Reset loads the present mode, so leaving reset is not an entry
    // Otherwise a sample in the first cycle after reset would be lost
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_prev_r <= mode;
        end else begin
            mode_prev_r <= mode;
        end
    end

    // Standby or ready into active
    assign enter_active = (mode == rsf_pkg::RSF_MODE_ACTIVE) &&
                          (mode_prev_r != rsf_pkg::RSF_MODE_ACTIVE);

    // Per-axis flag pairs
    rsf_axis_flag u_x (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear_all(enter_active),
        .sample_done(sample_done.x),
        .hi_read(hi_read.x),
        .ready_r(ready_w.x),
        .over_r(over_w.x)
    );
    rsf_axis_flag u_y (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear_all(enter_active),
        .sample_done(sample_done.y),
        .hi_read(hi_read.y),
        .ready_r(ready_w.y),
        .over_r(over_w.y)
    );
    rsf_axis_flag u_z (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear_all(enter_active),
        .sample_done(sample_done.z),
        .hi_read(hi_read.z),
        .ready_r(ready_w.z),
        .over_r(over_w.z)
    );

    // Read progress over the three high bytes
    always_comb begin
        read_seen_nxt = read_seen_r | hi_read;
    end
    assign all_read = &read_seen_nxt;
    assign set_done = &(new_set_r | sample_done);

    // Read progress bookkeeping, restarted by any axis sample or a full read
    always_ff @(posedge clk_sys) begin
        if (rst || enter_active) begin
            read_seen_r <= '0;
        end else if (|sample_done || all_read) begin
            read_seen_r <= '0;
        end else begin
            read_seen_r <= read_seen_nxt;
        end
    end

    // Axes collected towards a complete set
    always_ff @(posedge clk_sys) begin
        if (rst || enter_active || set_done) begin
            new_set_r <= '0;
        end else begin
            new_set_r <= new_set_r | sample_done;
        end
    end

    // Combined ready: any sample sets, full read clears; set wins
    always_ff @(posedge clk_sys) begin
        if (rst || enter_active) begin
            any_ready_r <= 1'b0;
        end else if (|sample_done) begin
            any_ready_r <= 1'b1;
        end else if (all_read) begin
            any_ready_r <= 1'b0;
        end
    end

    // Combined overwrite: complete set lands on an unread set
    always_ff @(posedge clk_sys) begin
        if (rst || enter_active) begin
            all_over_r <= 1'b0;
        end else if (set_done && any_ready_r && !all_read) begin
            all_over_r <= 1'b1;
        end else if (all_read) begin
            all_over_r <= 1'b0;
        end
    end

    // Status register image
    // Registered so every output leaves a flip-flop
    // Bit order, top to bottom:
    // all-overwrite, Z, Y, X overwrite
    // any-ready, Z, Y, X ready
    // Costs one edge of latency to the host
    // Glitch-free while the serial port shifts it out
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rate_sample_flags <= `RSF_FLAGS_RESET;
        end else begin
            rate_sample_flags <= {all_over_r, over_w.z, over_w.y, over_w.x,
                                  any_ready_r, ready_w.z, ready_w.y, ready_w.x};
        end
    end

    // Output sample store: newest replaces old, X hi at top
    // Each axis lane is written only by its own strobe
    // Unread data is overwritten, never queued
    // Lanes keep their value across mode entry
    // Only reset returns the store to zero
    // Low bytes of each lane stand beside the high bytes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sample_set_r <= 48'h000000000000;
        end else begin
            if (sample_done.x) begin
                sample_set_r[47:32] <= x_sample;
            end
            if (sample_done.y) begin
                sample_set_r[31:16] <= y_sample;
            end
            if (sample_done.z) begin
                sample_set_r[15:0] <= z_sample;
            end
        end
    end
endmodule

// file: rsf_cfg.svh
// Offsets, field positions and reset values of the rate sample status block
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH
`define RSF_ADDR_OUT_X_HI 8'h01
`define RSF_ADDR_OUT_Y_HI 8'h03
`define RSF_ADDR_OUT_Z_HI 8'h05
`define RSF_ADDR_FLAGS 8'h07
`define RSF_BIT_X_READY 0
`define RSF_BIT_Y_READY 1
`define RSF_BIT_Z_READY 2
`define RSF_BIT_ANY_READY 3
`define RSF_BIT_X_OVER 4
`define RSF_BIT_Y_OVER 5
`define RSF_BIT_Z_OVER 6
`define RSF_BIT_ALL_OVER 7
`define RSF_FLAGS_RESET 8'h00
`endif

// file: rsf_pkg.sv
// Types shared by the rate sample status block
package rsf_pkg;
    // Per-axis strobes, bit 0 X, bit 1 Y, bit 2 Z
    typedef struct packed {
        logic z;
        logic y;
        logic x;
    } rsf_axes_t;
    // Operating modes of the sensor
    typedef enum logic [1:0] {
        RSF_MODE_STANDBY,
        RSF_MODE_READY,
        RSF_MODE_ACTIVE
    } rsf_mode_t;
endpackage

// file: rsf_axis_flag.sv
// One axis: ready and overwrite flag pair
`timescale 1ns/1ps
module rsf_axis_flag (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clear_all,
    input wire logic sample_done,
    input wire logic hi_read,
    output logic ready_r,
    output logic over_r
);
    // Ready flag: set on sample, cleared by high-byte read; set wins
    always_ff @(posedge clk_sys) begin
        if (rst || clear_all) begin
            ready_r <= 1'b0;
        end else if (sample_done) begin
            ready_r <= 1'b1;
        end else if (hi_read) begin
            ready_r <= 1'b0;
        end
    end

    // Overwrite flag: new sample while previous still unread
    always_ff @(posedge clk_sys) begin
        if (rst || clear_all) begin
            over_r <= 1'b0;
        end else if (sample_done && ready_r && !hi_read) begin
            over_r <= 1'b1;
        end else if (hi_read) begin
            over_r <= 1'b0;
        end
    end
endmodule

// file: rsf_host.sv
// Host model issuing high-byte reads of the sample registers
`timescale 1ns/1ps
module rsf_host (
    input wire logic clk_sys,
    input wire logic req,
    input wire logic [7:0] addr,
    output logic rd_strobe,
    output logic [7:0] rd_addr
);
    initial rd_strobe = 1'b0;
    initial rd_addr = 8'h00;
    // Launch reads off the falling edge; idle address is inverted
    always @(negedge clk_sys) begin
        rd_strobe <= req;
        rd_addr <= req ? addr : ~rd_addr;
    end
endmodule

// file: rsf_flags_chk.sv
// Port assertions for the rate sample status flags
`timescale 1ns/1ps
`include "rsf_cfg.svh"
module rsf_flags_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire rsf_pkg::rsf_mode_t mode,
    input wire rsf_pkg::rsf_axes_t sample_done,
    input wire logic [15:0] x_sample,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_addr,
    input wire logic [7:0] rate_sample_flags,
    input wire logic [47:0] sample_set_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    rsf_pkg::rsf_mode_t mode_r; // Mode at last edge
    wire ent = mode == rsf_pkg::RSF_MODE_ACTIVE && mode_r != rsf_pkg::RSF_MODE_ACTIVE;
    wire rx = rd_strobe && rd_addr == `RSF_ADDR_OUT_X_HI; // X high read
    wire ry = rd_strobe && rd_addr == `RSF_ADDR_OUT_Y_HI; // Y high read
    wire rz = rd_strobe && rd_addr == `RSF_ADDR_OUT_Z_HI; // Z high read
    // Track mode for entry detection
    always_ff @(posedge clk_sys) mode_r <= mode;
    x_rdy_set_a:
    assert property (sample_done.x && !ent |-> ##2 rate_sample_flags[0])
        else $error("x ready not set");
    x_rdy_clr_a:
    assert property (rx && !sample_done.x && !ent |-> ##2 !rate_sample_flags[0])
        else $error("x ready not cleared");
    z_ovr_set_a:
    assert property (sample_done.z && !rz && !ent ##1 sample_done.z && !rz && !ent
        |-> ##2 rate_sample_flags[6]) else $error("z overwrite not set");
    y_ovr_clr_a:
    assert property (ry && !ent |-> ##2 !rate_sample_flags[5])
        else $error("y overwrite not cleared");
    any_rdy_a:
    assert property ((|sample_done) && !ent |-> ##2 rate_sample_flags[3])
        else $error("any ready not set");
    any_hold_a:
    assert property ($fell(rate_sample_flags[3]) |-> $past(rd_strobe, 2) || $past(ent, 2))
        else $error("any ready dropped without read");
    entry_clr_a:
    assert property (ent |-> ##2 rate_sample_flags == 8'h00)
        else $error("flags kept on active entry");
    samp_cap_a:
    assert property (sample_done.x |=> sample_set_r[47:32] == $past(x_sample))
        else $error("x sample not replaced");
endmodule
bind rsf_flags rsf_flags_chk u_chk (.clk_sys, .rst, .mode, .sample_done, .x_sample,
    .rd_strobe, .rd_addr, .rate_sample_flags, .sample_set_r);

// file: tb.sv
// Self-checking bench for the rate sample status flags
`timescale 1ns/1ps
`include "rsf_cfg.svh"
module tb;
    localparam rsf_pkg::rsf_mode_t ACT = rsf_pkg::RSF_MODE_ACTIVE;
    logic clk_sys, rst, req, rd_strobe, clr; // Clock, reset, host request
    rsf_pkg::rsf_mode_t mode, pm; // Mode driven and mode at last edge
    rsf_pkg::rsf_axes_t sample_done; // Axis strobes
    logic [15:0] xs, ys, zs; // Sample data
    logic [7:0] rd_addr, addr, flags, m, ef; // Model flags and expected byte
    logic [47:0] set_w, es; // Samples seen and expected
    logic [2:0] d, rd, rm; // Strobes, reads, high bytes read
    logic [31:0] r = 32'h11E6; // Random state
    int fails = 0, checks = 0;
    rsf_flags dut (.clk_sys, .rst, .mode, .sample_done, .x_sample(xs), .y_sample(ys),
        .z_sample(zs), .rd_strobe, .rd_addr, .rate_sample_flags(flags), .sample_set_r(set_w));
    rsf_host u_host (.clk_sys, .req, .addr, .rd_strobe, .rd_addr);
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Reference model; status byte lags internal flags by one edge
    always @(posedge clk_sys) begin
        d = sample_done;
        rd = {3{rd_strobe}} & {rd_addr == `RSF_ADDR_OUT_Z_HI, rd_addr == `RSF_ADDR_OUT_Y_HI,
            rd_addr == `RSF_ADDR_OUT_X_HI};
        ef = rst ? 8'h00 : m;
        es = rst ? 48'h0 : {d[0] ? xs : es[47:32], d[1] ? ys : es[31:16], d[2] ? zs : es[15:0]};
        clr = (rm | rd) == 3'h7;
        rm = (|d || clr) ? 3'h0 : rm | rd;
        m = {(&d & m[3] & ~clr) | (m[7] & ~clr), d & m[2:0] & ~rd | m[6:4] & ~rd,
            |d | (m[3] & ~clr), d | m[2:0] & ~rd};
        if (rst || clr || (mode == ACT && pm != ACT)) begin
            rm = 3'h0;
        end
        if (rst || (mode == ACT && pm != ACT)) begin
            m = 8'h00;
        end
        pm = mode;
    end
    task automatic chk(input logic [47:0] exp, got, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Random samples, high-byte reads and mode changes
    task automatic run(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            chk(ef, flags, "flags");
            chk(es, set_w, "samples");
            r = lfsr(r);
            req <= r[2];
            addr <= {5'h00, r[4:3], 1'b1};
            sample_done <= (r[1:0] == 2'h0 && mode == ACT && r[12:8] != 5'h0) ? 3'h7 : 3'h0;
            mode <= r[12:8] != 5'h0 ? ACT :
                (r[13] ? rsf_pkg::RSF_MODE_READY : rsf_pkg::RSF_MODE_STANDBY);
            xs <= r[31:16];
            ys <= r[15:0];
            zs <= r[23:8];
        end
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Watchdog
    initial begin
        #1000000;
        fails++;
        end_sim;
    end
    initial begin
        {rst, req, addr, mode, sample_done, xs, ys, zs} = {1'b1, 1'b0, 8'h01, ACT, 51'h0};
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        run(1500);
        $display("random traffic done");
        rst = 1'b1;
        run(2);
        rst = 1'b0;
        run(1500);
        $display("reset mid-run done");
        end_sim;
    end
endmodule
